// >>> rtl/tst_params.svh
`ifndef TST_PARAMS_SVH
`define TST_PARAMS_SVH

// sizes
`define TST_LEVELS        8
`define TST_PATTERNS      8
`define TST_DEPTH         64

// states kept after the trigger, per trigger position
`define TST_POST_START    7'h3f
`define TST_POST_CENTER   7'h20
`define TST_POST_END      7'h00

// register byte offsets
`define TST_OFS_CTRL      10'h000
`define TST_OFS_STATUS    10'h004
`define TST_OFS_MASK      10'h008
`define TST_OFS_CNT_COND  10'h00c
`define TST_OFS_PRE_COND  10'h010
`define TST_OFS_RNG_MIN   10'h014
`define TST_OFS_RNG_MAX   10'h018
`define TST_OFS_RNG_CFG   10'h01c
`define TST_OFS_AVAIL     10'h020
`define TST_OFS_IDX       10'h024
`define TST_OFS_ENT_W0    10'h028
`define TST_OFS_ENT_W1    10'h02c
`define TST_OFS_ENT_W2    10'h030
`define TST_OFS_LEVEL     10'h034
`define TST_OFS_PAT_BASE  10'h100
`define TST_OFS_LEV_BASE  10'h200

// control field positions
`define TST_CTRL_START    0
`define TST_CTRL_HALT     1
`define TST_CTRL_TRIG_LSB 4
`define TST_CTRL_POS_LSB  8
`define TST_CTRL_BRK      12

// status / mask bit positions
`define TST_ST_TRIG       0
`define TST_ST_DONE       1

// reset values
`define TST_RST_TRIG_LVL  3'h1
`define TST_RST_MASK      2'h0

// predefined status qualifiers: value and mask
`define TST_STAT_RD_VAL   8'h01
`define TST_STAT_RD_MSK   8'h01
`define TST_STAT_WR_VAL   8'h00
`define TST_STAT_WR_MSK   8'h01
`define TST_STAT_FE_VAL   8'h02
`define TST_STAT_FE_MSK   8'h02

`endif

// >>> rtl/tst_pkg.sv
package tst_pkg;

  typedef enum logic [1:0] {
    TST_C_ANY  = 2'h0,
    TST_C_NONE = 2'h1,
    TST_C_EXPR = 2'h2
  } tst_cmode_e;

  typedef enum logic [1:0] {
    TST_IDLE = 2'h0,
    TST_PRE  = 2'h1,
    TST_POST = 2'h3,
    TST_DONE = 2'h2
  } tst_run_e;

  typedef enum logic [1:0] {
    TST_POS_START  = 2'h0,
    TST_POS_CENTER = 2'h1,
    TST_POS_END    = 2'h2
  } tst_pos_e;

  // condition word, 15 bits as written by software
  typedef struct packed {
    tst_cmode_e mode;
    logic       and_op;
    logic       nor2;
    logic       nor1;
    logic [4:0] sel2;
    logic [4:0] sel1;
  } tst_cond_s;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
    logic [7:0]  stat;
  } tst_bus_s;

  typedef struct packed {
    logic [23:0] a_val;
    logic [23:0] a_msk;
    logic [15:0] d_val;
    logic [15:0] d_msk;
    logic [7:0]  s_val;
    logic [7:0]  s_msk;
    logic [1:0]  s_pre;
    logic        direct;
    logic        inv;
  } tst_pat_s;

  typedef struct packed {
    logic [2:0] ptgt;
    logic [2:0] stgt;
    tst_cond_s  pc;
    tst_cond_s  sc;
    tst_cond_s  stc;
  } tst_lev_s;

  typedef struct packed {
    logic        trig;
    logic        pre_v;
    logic [23:0] pre_a;
    logic [15:0] cnt;
    tst_bus_s    st;
  } tst_entry_s;

  typedef struct packed {
    tst_run_e    run;
    logic [2:0]  lvl;
    logic [5:0]  wptr;
    logic [6:0]  nst;
    logic [6:0]  post;
    logic [15:0] cnt;
    logic [23:0] pre_a;
    logic        pre_v;
    logic [2:0]  trig_lvl;
    tst_pos_e    pos;
    logic        brk_en;
    tst_cond_s   cnt_c;
    tst_cond_s   pre_c;
    logic [23:0] r_min;
    logic [23:0] r_max;
    logic        r_data;
    tst_pat_s [7:0] pat;
    tst_lev_s [7:0] lev;
    logic [1:0]  sts;
    logic [1:0]  msk;
    logic [5:0]  ridx;
    logic [31:0] rdata;
    logic        irq;
    logic        brk;
    logic        busy;
  } tst_state_s;

endpackage

// >>> rtl/tst_trigger.sv
`timescale 1ns/100ps
`include "tst_params.svh"

module tst_trigger
  import tst_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // captured bus states
  input  wire logic        st_valid,
  input  tst_bus_s         st_bus,
  input  wire logic        arm_in,
  // register port
  input  wire logic [9:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // status outputs
  output logic             irq,
  output logic             brk_req,
  output logic             busy
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // predefined status qualifier as {value, mask}
  function automatic logic [15:0] stat_pre(input logic [1:0] sel);
    case (sel)
      2'h1:    stat_pre = {`TST_STAT_RD_VAL, `TST_STAT_RD_MSK};
      2'h2:    stat_pre = {`TST_STAT_WR_VAL, `TST_STAT_WR_MSK};
      2'h3:    stat_pre = {`TST_STAT_FE_VAL, `TST_STAT_FE_MSK};
      default: stat_pre = 16'h0000;
    endcase
  endfunction

  // one pattern against one state; mask bit set means compare
  function automatic logic pat_hit(input tst_pat_s p, input tst_bus_s b);
    logic [15:0] sq;
    logic        ok;
    sq = p.direct ? {p.s_val, p.s_msk} : stat_pre(p.s_pre);
    ok = (((b.addr ^ p.a_val) & p.a_msk) == 24'h000000) &&
         (((b.data ^ p.d_val) & p.d_msk) == 16'h0000) &&
         (((b.stat ^ sq[15:8]) & sq[7:0]) == 8'h00);
    pat_hit = ok ^ p.inv;
  endfunction

  // condition over resources: hits[7:0] patterns, [8] range, [9] arm
  function automatic logic cond_ok(input tst_cond_s c, input logic [9:0] h);
    logic g1;
    logic g2;
    g1 = |(c.sel1 & {h[8], h[3:0]}) ^ c.nor1;
    g2 = |(c.sel2 & {h[9], h[7:4]}) ^ c.nor2;
    case (c.mode)
      TST_C_ANY:  cond_ok = 1'b1;
      TST_C_NONE: cond_ok = 1'b0;
      TST_C_EXPR: cond_ok = c.and_op ? (g1 & g2) : (g1 | g2);
      default:    cond_ok = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // storage

  tst_state_s s_reg;
  tst_state_s s_next;
  tst_entry_s mem [0:`TST_DEPTH-1];
  logic       mem_we;
  logic [5:0] mem_wa;
  tst_entry_s mem_wd;

  // working signals of the combinational process
  logic [9:0]  hits;
  logic [23:0] r_val;
  tst_lev_s    cl;
  logic        pm;
  logic        sm;
  logic [2:0]  nxt;
  logic        enter_trig;
  logic        store;
  logic        cnt_hit;
  logic [6:0]  post_init;
  logic [1:0]  ev;
  logic [1:0]  clr;
  logic [6:0]  avail;
  logic [5:0]  phys;
  tst_entry_s  rent;
  logic        running;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    s_next = s_reg;
    s_next.brk = 1'b0;
    mem_we = 1'b0;
    mem_wa = s_reg.wptr;
    mem_wd = '0;
    ev = 2'h0;
    clr = 2'h0;
    running = (s_reg.run == TST_PRE) || (s_reg.run == TST_POST);

    // resource hits for this state
    for (int i = 0; i < `TST_PATTERNS; i++)
    begin
      hits[i] = pat_hit(s_reg.pat[i], st_bus);
    end
    r_val = s_reg.r_data ? {8'h00, st_bus.data} : st_bus.addr;
    hits[8] = (r_val >= s_reg.r_min) && (r_val <= s_reg.r_max);
    hits[9] = arm_in;

    // sequencer decisions against the active level
    cl = s_reg.lev[s_reg.lvl];
    pm = cond_ok(cl.pc, hits);
    sm = cond_ok(cl.sc, hits);
    nxt = pm ? cl.ptgt : (sm ? cl.stgt : s_reg.lvl);
    enter_trig = (s_reg.run == TST_PRE) && (pm || sm) &&
                 (s_reg.trig_lvl != 3'h0) && (nxt == s_reg.trig_lvl) &&
                 (s_reg.lvl != s_reg.trig_lvl);
    store = cond_ok(cl.stc, hits) || enter_trig;
    cnt_hit = cond_ok(s_reg.cnt_c, hits);

    case (s_reg.pos)
      TST_POS_START:  post_init = `TST_POST_START;
      TST_POS_CENTER: post_init = `TST_POST_CENTER;
      default:        post_init = `TST_POST_END;
    endcase

    // one evaluation per valid captured state
    if (st_valid && running)
    begin
      s_next.lvl = nxt;
      s_next.cnt = s_reg.cnt + 16'(cnt_hit);
      if (store)
      begin
        mem_we = 1'b1;
        mem_wd.trig = enter_trig;
        mem_wd.pre_v = s_reg.pre_v;
        mem_wd.pre_a = s_reg.pre_a;
        mem_wd.cnt = s_reg.cnt + 16'(cnt_hit);
        mem_wd.st = st_bus;
        s_next.cnt = 16'h0000;
        s_next.pre_v = 1'b0;
        s_next.wptr = s_reg.wptr + 6'h01;
        if (s_reg.nst != 7'(`TST_DEPTH))
        begin
          s_next.nst = s_reg.nst + 7'h01;
        end
      end
      else if (cond_ok(s_reg.pre_c, hits))
      begin
        s_next.pre_a = st_bus.addr;
        s_next.pre_v = 1'b1;
      end
      else
      begin
        s_next.pre_v = 1'b0;                                   // only the state just before
      end

      if (enter_trig)
      begin
        ev[`TST_ST_TRIG] = 1'b1;
        s_next.brk = s_reg.brk_en;
        s_next.post = post_init;
        if (post_init == 7'h00)
        begin
          s_next.run = TST_DONE;
          ev[`TST_ST_DONE] = 1'b1;
        end
        else
        begin
          s_next.run = TST_POST;
        end
      end
      else if ((s_reg.run == TST_POST) && store)
      begin
        s_next.post = s_reg.post - 7'h01;
        if (s_reg.post == 7'h01)
        begin
          s_next.run = TST_DONE;
          ev[`TST_ST_DONE] = 1'b1;
        end
      end
    end

    // register writes; start and halt override the sequencer
    if (reg_wr)
    begin
      case (reg_addr)
        `TST_OFS_CTRL:
        begin
          s_next.trig_lvl = reg_wdata[`TST_CTRL_TRIG_LSB +: 3];
          s_next.pos = tst_pos_e'(reg_wdata[`TST_CTRL_POS_LSB +: 2]);
          s_next.brk_en = reg_wdata[`TST_CTRL_BRK];
          if (reg_wdata[`TST_CTRL_START])
          begin
            s_next.run = TST_PRE;
            s_next.lvl = 3'h0;
            s_next.wptr = 6'h00;
            s_next.nst = 7'h00;
            s_next.cnt = 16'h0000;
            s_next.pre_v = 1'b0;
            s_next.post = 7'h00;
            s_next.brk = 1'b0;
            ev = 2'h0;
          end
          else if (reg_wdata[`TST_CTRL_HALT] && running)
          begin
            s_next.run = TST_DONE;
            ev[`TST_ST_DONE] = 1'b1;
          end
        end
        `TST_OFS_STATUS:   clr = reg_wdata[1:0];
        `TST_OFS_MASK:     s_next.msk = reg_wdata[1:0];
        `TST_OFS_CNT_COND: s_next.cnt_c = tst_cond_s'(reg_wdata[14:0]);
        `TST_OFS_PRE_COND: s_next.pre_c = tst_cond_s'(reg_wdata[14:0]);
        `TST_OFS_RNG_MIN:  s_next.r_min = reg_wdata[23:0];
        `TST_OFS_RNG_MAX:  s_next.r_max = reg_wdata[23:0];
        `TST_OFS_RNG_CFG:  s_next.r_data = reg_wdata[0];
        `TST_OFS_IDX:      s_next.ridx = reg_wdata[5:0];
        default:
        begin
          // pattern and level tables: 16 bytes per entry
          if (reg_addr[9:7] == 3'h2)
          begin
            case (reg_addr[3:2])
              2'h0: s_next.pat[reg_addr[6:4]].a_val = reg_wdata[23:0];
              2'h1: s_next.pat[reg_addr[6:4]].a_msk = reg_wdata[23:0];
              2'h2:
              begin
                s_next.pat[reg_addr[6:4]].d_val = reg_wdata[15:0];
                s_next.pat[reg_addr[6:4]].d_msk = reg_wdata[31:16];
              end
              default:
              begin
                s_next.pat[reg_addr[6:4]].s_val = reg_wdata[7:0];
                s_next.pat[reg_addr[6:4]].s_msk = reg_wdata[15:8];
                s_next.pat[reg_addr[6:4]].s_pre = reg_wdata[17:16];
                s_next.pat[reg_addr[6:4]].direct = reg_wdata[20];
                s_next.pat[reg_addr[6:4]].inv = reg_wdata[31];
              end
            endcase
          end
          else if (reg_addr[9:7] == 3'h4)
          begin
            case (reg_addr[3:2])
              2'h0:
              begin
                s_next.lev[reg_addr[6:4]].pc = tst_cond_s'(reg_wdata[14:0]);
                s_next.lev[reg_addr[6:4]].ptgt = reg_wdata[18:16];
              end
              2'h1:
              begin
                s_next.lev[reg_addr[6:4]].sc = tst_cond_s'(reg_wdata[14:0]);
                s_next.lev[reg_addr[6:4]].stgt = reg_wdata[18:16];
              end
              2'h2: s_next.lev[reg_addr[6:4]].stc = tst_cond_s'(reg_wdata[14:0]);
              default: s_next.lev[reg_addr[6:4]].stc = s_reg.lev[reg_addr[6:4]].stc;
            endcase
          end
        end
      endcase
    end

    // sticky status: a new event wins over a same-cycle clear
    s_next.sts = (s_reg.sts & ~clr) | ev;
    s_next.irq = |(s_next.sts & s_next.msk);
    s_next.busy = (s_next.run == TST_PRE) || (s_next.run == TST_POST);

    // an odd last state stays hidden until the run has ended
    avail = (s_reg.run == TST_DONE) ? s_reg.nst : {s_reg.nst[6:1], 1'b0};
    phys = ((s_reg.nst == 7'(`TST_DEPTH)) ? s_reg.wptr : 6'h00) + s_reg.ridx;
    rent = ({1'b0, s_reg.ridx} < avail) ? mem[phys] : '0;

    // read data stand one cycle after the strobe, zero otherwise
    s_next.rdata = 32'h00000000;
    if (reg_rd)
    begin
      case (reg_addr)
        `TST_OFS_CTRL:     s_next.rdata = {19'h00000, s_reg.brk_en, 2'h0, s_reg.pos,
                                           1'b0, s_reg.trig_lvl, 4'h0};
        `TST_OFS_STATUS:   s_next.rdata = {30'h00000000, s_reg.sts};
        `TST_OFS_MASK:     s_next.rdata = {30'h00000000, s_reg.msk};
        `TST_OFS_CNT_COND: s_next.rdata = {17'h00000, s_reg.cnt_c};
        `TST_OFS_PRE_COND: s_next.rdata = {17'h00000, s_reg.pre_c};
        `TST_OFS_RNG_MIN:  s_next.rdata = {8'h00, s_reg.r_min};
        `TST_OFS_RNG_MAX:  s_next.rdata = {8'h00, s_reg.r_max};
        `TST_OFS_RNG_CFG:  s_next.rdata = {31'h00000000, s_reg.r_data};
        `TST_OFS_AVAIL:    s_next.rdata = {25'h0000000, avail};
        `TST_OFS_IDX:      s_next.rdata = {26'h0000000, s_reg.ridx};
        `TST_OFS_ENT_W0:   s_next.rdata = {rent.st.stat, rent.st.addr};
        `TST_OFS_ENT_W1:   s_next.rdata = {rent.cnt, rent.st.data};
        `TST_OFS_ENT_W2:   s_next.rdata = {rent.trig, rent.pre_v, 6'h00, rent.pre_a};
        `TST_OFS_LEVEL:    s_next.rdata = {24'h000000, s_reg.run, 3'h0, s_reg.lvl};
        default:           s_next.rdata = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
      s_reg.trig_lvl <= `TST_RST_TRIG_LVL;
      s_reg.msk <= `TST_RST_MASK;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // trace memory; no reset, contents are only read below the fill mark
  always_ff @(posedge clock)
  begin
    if (mem_we)
    begin
      mem[mem_wa] <= mem_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register

  assign reg_rdata = s_reg.rdata;
  assign irq = s_reg.irq;
  assign brk_req = s_reg.brk;
  assign busy = s_reg.busy;

endmodule

// >>> tb/tst_bus_src.sv
`timescale 1ns/100ps
module tst_bus_src
  import tst_pkg::*;
(
  // sample clock
  input  wire logic clock,
  // captured state towards the sequencer
  output logic      st_valid,
  output tst_bus_s  st_bus,
  output logic      arm_in
);
  // bus quiet at time zero, arm low until send_arm raises it
  initial
  begin
    st_valid = 1'b0;
    st_bus   = '0;
    arm_in   = 1'b0;
  end

  // one bus state for one cycle; afterwards the lines carry the
  // inverse so a stale sample never passes for a real one
  task automatic send(input tst_bus_s s);
    @(posedge clock);
    st_valid <= 1'b1;
    st_bus   <= s;
    @(posedge clock);
    st_valid <= 1'b0;
    st_bus   <= ~s;
  endtask

  // as send, with the external arm line raised for that one state
  task automatic send_arm(input tst_bus_s s);
    @(posedge clock);
    st_valid <= 1'b1;
    st_bus   <= s;
    arm_in   <= 1'b1;
    @(posedge clock);
    st_valid <= 1'b0;
    st_bus   <= ~s;
    arm_in   <= 1'b0;
  endtask
endmodule

// >>> tb/tst_trigger_sva.sv
`timescale 1ns/100ps
`include "tst_params.svh"
module tst_trigger_chk
  import tst_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // captured states
  input  wire logic        st_valid,
  input  tst_bus_s         st_bus,
  input  wire logic        arm_in,
  // register port
  input  wire logic [9:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_rdata,
  // status outputs
  input  wire logic        irq,
  input  wire logic        brk_req,
  input  wire logic        busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic       ctrl_wr;
  logic       brk_en_reg;
  logic [1:0] mask_reg;

  // shadow copies of the break enable and mask as software wrote them
  assign ctrl_wr = reg_wr && reg_addr == `TST_OFS_CTRL;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      brk_en_reg <= 1'b0;
      mask_reg   <= `TST_RST_MASK;
    end
    else
    begin
      if (ctrl_wr)
        brk_en_reg <= reg_wdata[`TST_CTRL_BRK];
      if (reg_wr && reg_addr == `TST_OFS_MASK)
        mask_reg <= reg_wdata[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  sequence s_start;
    ctrl_wr && reg_wdata[`TST_CTRL_START] && !reg_wdata[`TST_CTRL_HALT];
  endsequence
  sequence s_halt;
    ctrl_wr && reg_wdata[`TST_CTRL_HALT] && !reg_wdata[`TST_CTRL_START];
  endsequence
  sequence s_trig_state;
    st_valid && busy ##1 brk_req;
  endsequence

  a_start_runs: assert property (s_start |=> busy)
    else $error("start did not raise busy");
  a_halt_stops: assert property (s_halt |=> !busy)
    else $error("halt left measurement running");
  a_idle_holds: assert property (!busy && !(ctrl_wr && reg_wdata[0]) |=> !busy)
    else $error("busy rose without start");
  a_run_holds: assert property (busy && !ctrl_wr && !st_valid |=> busy)
    else $error("busy fell without state or halt");
  a_brk_cause: assert property (brk_req |-> $past(st_valid) && $past(busy) && brk_en_reg)
    else $error("break request without enabled triggering state");
  a_brk_pulse: assert property (s_trig_state |=> !brk_req)
    else $error("break request longer than one cycle");
  a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read answer cycle");
  a_irq_masked: assert property (mask_reg == 2'h0 && $past(mask_reg) == 2'h0 |-> !irq)
    else $error("interrupt with everything masked");
  a_ctrl_cmds: assert property (reg_rd && reg_addr == `TST_OFS_CTRL |=> reg_rdata[1:0] == 2'h0)
    else $error("command bits read back nonzero");
endmodule

bind tst_trigger tst_trigger_chk u_chk (
  .clock     (clock),
  .rst_n     (rst_n),
  .st_valid  (st_valid),
  .st_bus    (st_bus),
  .arm_in    (arm_in),
  .reg_addr  (reg_addr),
  .reg_wdata (reg_wdata),
  .reg_wr    (reg_wr),
  .reg_rd    (reg_rd),
  .reg_rdata (reg_rdata),
  .irq       (irq),
  .brk_req   (brk_req),
  .busy      (busy)
);

// >>> tb/test_trace_sequence_trigger.sv
`timescale 1ns/100ps
`include "tst_params.svh"
module test_trace_sequence_trigger
  import tst_pkg::*;
;
  logic        clock     = 1'b0;
  logic        rst_n     = 1'b0;
  logic [9:0]  reg_addr  = 10'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata;
  logic        st_valid;
  logic        arm_in;
  logic        irq;
  logic        brk_req;
  logic        busy;
  tst_bus_s    st_bus;
  int          fails     = 0;
  int          checked   = 0;

  // 200 MHz sample clock
  always #2.5 clock = ~clock;

  tst_bus_src u_src (.clock(clock), .st_valid(st_valid), .st_bus(st_bus), .arm_in(arm_in));

  tst_trigger u_dut (
    .clock     (clock),
    .rst_n     (rst_n),
    .st_valid  (st_valid),
    .st_bus    (st_bus),
    .arm_in    (arm_in),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .irq       (irq),
    .brk_req   (brk_req),
    .busy      (busy)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  // read data are looked at only in the cycle after the strobe
  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // bounded wait for the measurement to finish
  task automatic wait_idle;
    int n;
    for (n = 0; n < 8 && busy !== 1'b0; n++)
      @(posedge clock);
    if (busy !== 1'b0)
    begin
      fails++;
      $display("mismatch at %0t: busy %h expected %h", $time, busy, 1'b0);
      give_verdict;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic s_defaults;
    rd(`TST_OFS_CTRL, 32'h10);
    rd(`TST_OFS_MASK, 32'h0);
    rd(`TST_OFS_STATUS, 32'h0);
    rd(`TST_OFS_LEVEL, 32'h0);
    wr(10'h03c, 32'hffffffff);
    rd(10'h03c, 32'h0);
  endtask

  // both branches match on the trigger state; trigger at end finishes at once
  task automatic s_trigger_end;
    wr(`TST_OFS_PAT_BASE, 32'h1000);
    wr(`TST_OFS_PAT_BASE + 10'h004, 32'hffffff);
    wr(`TST_OFS_PAT_BASE + 10'h010, 32'h1000);
    wr(`TST_OFS_PAT_BASE + 10'h014, 32'hffffff);
    wr(`TST_OFS_LEV_BASE, 32'h24001);
    wr(`TST_OFS_LEV_BASE + 10'h004, 32'h14002);
    wr(`TST_OFS_LEV_BASE + 10'h008, 32'h2000);
    wr(`TST_OFS_MASK, 32'h3);
    wr(`TST_OFS_CTRL, 32'h1221);
    rd(`TST_OFS_LEVEL, 32'h40);
    u_src.send('{24'h000500, 16'h1234, 8'h01});
    rd(`TST_OFS_LEVEL, 32'h40);
    u_src.send('{24'h001000, 16'hbeef, 8'h02});
    // the break pulse stands only in the cycle after the triggering state
    #1 chk(brk_req, 32'h1);
    chk(irq, 32'h1);
    wait_idle;
    rd(`TST_OFS_LEVEL, 32'h82);
    rd(`TST_OFS_STATUS, 32'h3);
    rd(`TST_OFS_AVAIL, 32'h1);
    wr(`TST_OFS_IDX, 32'h0);
    rd(`TST_OFS_ENT_W0, 32'h02001000);
    rd(`TST_OFS_ENT_W1, 32'h0002beef);
    rd(`TST_OFS_ENT_W2, 32'hc0000500);
    wr(`TST_OFS_IDX, 32'h1);
    rd(`TST_OFS_ENT_W0, 32'h0);
    rd(`TST_OFS_CTRL, 32'h1220);
    wr(`TST_OFS_STATUS, 32'h1);
    rd(`TST_OFS_STATUS, 32'h2);
    wr(`TST_OFS_STATUS, 32'h2);
    rd(`TST_OFS_STATUS, 32'h0);
    chk(irq, 32'h0);
  endtask

  // center position: 32 states after the trigger, pairs until done
  task automatic s_center_full;
    wr(`TST_OFS_MASK, 32'h0);
    wr(`TST_OFS_LEV_BASE, 32'h10000);
    wr(`TST_OFS_LEV_BASE + 10'h004, 32'h2000);
    wr(`TST_OFS_LEV_BASE + 10'h008, 32'h0);
    wr(`TST_OFS_CTRL, 32'h111);
    u_src.send('{24'h000200, 16'h0001, 8'h00});
    #1 chk(brk_req, 32'h0);
    chk(irq, 32'h0);
    repeat (30) u_src.send('{24'h000300, 16'h0002, 8'h01});
    #1 chk(busy, 32'h1);
    rd(`TST_OFS_AVAIL, 32'h1e);
    u_src.send('{24'h000304, 16'h0003, 8'h01});
    #1 chk(busy, 32'h1);
    u_src.send('{24'h000308, 16'h0004, 8'h01});
    #1 chk(busy, 32'h0);
    rd(`TST_OFS_AVAIL, 32'h21);
    rd(`TST_OFS_STATUS, 32'h3);
    wr(`TST_OFS_STATUS, 32'h3);
  endtask

  // waiting on a state that never comes; halt ends it
  task automatic s_halt_early;
    wr(`TST_OFS_LEV_BASE, 32'h2000);
    wr(`TST_OFS_CTRL, 32'h111);
    u_src.send('{24'h000400, 16'h0005, 8'h00});
    #1 chk(busy, 32'h1);
    rd(`TST_OFS_AVAIL, 32'h0);
    rd(`TST_OFS_LEVEL, 32'h40);
    wr(`TST_OFS_CTRL, 32'h112);
    #1 chk(busy, 32'h0);
    rd(`TST_OFS_AVAIL, 32'h1);
    rd(`TST_OFS_STATUS, 32'h2);
  endtask

  // data range, arm, inverted direct-status pattern, nor store, and-ed branch
  task automatic s_qualifiers;
    wr(`TST_OFS_RNG_MIN, 32'h100);
    wr(`TST_OFS_RNG_MAX, 32'h1ff);
    wr(`TST_OFS_RNG_CFG, 32'h1);
    wr(`TST_OFS_PAT_BASE + 10'h028, 32'h00ff0034);
    wr(`TST_OFS_PAT_BASE + 10'h02c, 32'h80108080);
    wr(`TST_OFS_LEV_BASE, 32'h25210);
    wr(`TST_OFS_LEV_BASE + 10'h004, 32'h14004);
    wr(`TST_OFS_LEV_BASE + 10'h008, 32'h4401);
    wr(`TST_OFS_CNT_COND, 32'h4004);
    wr(`TST_OFS_PRE_COND, 32'h2000);
    wr(`TST_OFS_CTRL, 32'h221);
    u_src.send('{24'h001000, 16'h0134, 8'h80});
    rd(`TST_OFS_LEVEL, 32'h40);
    u_src.send('{24'h002000, 16'h0134, 8'h00});
    rd(`TST_OFS_LEVEL, 32'h41);
    u_src.send('{24'h001000, 16'h0234, 8'h81});
    u_src.send_arm('{24'h001000, 16'h0234, 8'h80});
    rd(`TST_OFS_LEVEL, 32'h40);
    u_src.send_arm('{24'h001000, 16'h01ff, 8'h80});
    #1 chk(busy, 32'h0);
    chk(brk_req, 32'h0);
    rd(`TST_OFS_LEVEL, 32'h82);
    rd(`TST_OFS_AVAIL, 32'h3);
    wr(`TST_OFS_IDX, 32'h0);
    rd(`TST_OFS_ENT_W0, 32'h00002000);
    rd(`TST_OFS_ENT_W1, 32'h00010134);
    wr(`TST_OFS_IDX, 32'h1);
    rd(`TST_OFS_ENT_W0, 32'h81001000);
    rd(`TST_OFS_ENT_W1, 32'h00000234);
    wr(`TST_OFS_IDX, 32'h2);
    rd(`TST_OFS_ENT_W1, 32'h000101ff);
  endtask

  // reset in mid-run drops the measurement and the configuration
  task automatic s_reset_mid;
    wr(`TST_OFS_CTRL, 32'h1131);
    #1 chk(busy, 32'h1);
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    #1 chk(busy, 32'h0);
    @(posedge clock);
    rst_n <= 1'b1;
    rd(`TST_OFS_LEVEL, 32'h0);
    rd(`TST_OFS_CTRL, 32'h10);
    rd(`TST_OFS_STATUS, 32'h0);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // reset for four cycles, then the scenarios in turn
  initial
  begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    s_defaults;
    s_trigger_end;
    s_center_full;
    s_halt_early;
    s_qualifiers;
    s_reset_mid;
    give_verdict;
  end
endmodule
